/* src/trng_pkg.sv */
package trng_pkg;
  // clock
  localparam int unsigned CLK_MHZ = 125;
  localparam int unsigned CLK_PERIOD_NS = 8;
  // total-failure test: run of identical raw bits that marks a dead source
  localparam logic [5:0] TF_RUN = 6'h20;
  // online test window and accepted count of ones
  localparam logic [7:0] WIN_LAST = 8'hff;
  localparam logic [8:0] ONES_LO = 9'h060;
  localparam logic [8:0] ONES_HI = 9'h0a0;
  // output word lengths
  localparam logic [4:0] WLEN_8 = 5'h08;
  localparam logic [4:0] WLEN_16 = 5'h10;
  // alarm self-test: longest wait for the alarm lines to answer
  localparam int unsigned ALARM_WAIT_NS = 100;
  localparam logic [3:0] ALARM_WAIT_CYC = 4'(ALARM_WAIT_NS / CLK_PERIOD_NS);
  localparam int unsigned ALARM_LINES = 4;
  // synchroniser depth: line levels seen earlier predate the injection
  localparam logic [3:0] ALARM_SETTLE = 4'h2;
  // autonomous self-test period
  localparam int unsigned AUTO_TEST_US = 1000;
  localparam int unsigned AUTO_TEST_CYC_DEF = AUTO_TEST_US * CLK_MHZ;
  localparam int unsigned AUTO_W = 17;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_START = 4'h2,
    ST_RUN = 4'h4,
    ST_FAIL = 4'h8
  } gen_state_e;
endpackage

/* src/health_tests.sv */
`timescale 1ns/1ns
module health_tests (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic clr,
  input wire logic bit_in,
  input wire logic bit_stb,
  output logic tot_fail,
  output logic onl_fail,
  output logic onl_pass
);
  logic last_r, last_nxt;
  logic [5:0] run_r, run_nxt;
  logic [7:0] win_r, win_nxt;
  logic [8:0] ones_r, ones_nxt, ones_sum;
  logic tot_r, tot_nxt, onf_r, onf_nxt, onp_r, onp_nxt;

  always_comb begin
    last_nxt = last_r;
    run_nxt = run_r;
    win_nxt = win_r;
    ones_nxt = ones_r;
    tot_nxt = 1'b0;
    onf_nxt = 1'b0;
    onp_nxt = 1'b0;
    ones_sum = ones_r + {8'h00, bit_in};
    if (clr) begin
      last_nxt = 1'b0;
      run_nxt = '0;
      win_nxt = '0;
      ones_nxt = '0;
    end else if (bit_stb) begin
      last_nxt = bit_in;
      if (run_r != '0 && bit_in == last_r) begin
        if (run_r == trng_pkg::TF_RUN - 6'h01) begin
          tot_nxt = 1'b1;
        end
        if (run_r != trng_pkg::TF_RUN) begin
          run_nxt = run_r + 6'h01;
        end
      end else begin
        run_nxt = 6'h01;
      end
      win_nxt = win_r + 8'h01;
      ones_nxt = ones_sum;
      if (win_r == trng_pkg::WIN_LAST) begin
        ones_nxt = '0;
        if (ones_sum < trng_pkg::ONES_LO || ones_sum > trng_pkg::ONES_HI) begin
          onf_nxt = 1'b1;
        end else begin
          onp_nxt = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      last_r <= 1'b0;
      run_r <= '0;
      win_r <= '0;
      ones_r <= '0;
      tot_r <= 1'b0;
      onf_r <= 1'b0;
      onp_r <= 1'b0;
    end else begin
      last_r <= last_nxt;
      run_r <= run_nxt;
      win_r <= win_nxt;
      ones_r <= ones_nxt;
      tot_r <= tot_nxt;
      onf_r <= onf_nxt;
      onp_r <= onp_nxt;
    end
  end

  assign tot_fail = tot_r;
  assign onl_fail = onf_r;
  assign onl_pass = onp_r;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);

  property p_win_moves;
    bit_stb && !clr |=> win_r != $past(win_r);
  endproperty
  a_win_moves: assert property (p_win_moves) else $error("window did not advance");

  property p_tot_run;
    tot_r |-> run_r == trng_pkg::TF_RUN;
  endproperty
  a_tot_run: assert property (p_tot_run) else $error("total failure without full run");

  property p_verdict_once;
    (onf_r || onp_r) |-> !(onf_r && onp_r) && win_r == '0 && ones_r == '0;
  endproperty
  a_verdict_once: assert property (p_verdict_once) else $error("verdict off window end");
endmodule

/* src/trng_health_gate.sv */
`timescale 1ns/1ns
module trng_health_gate #(
  parameter int unsigned AUTO_TEST_CYC = trng_pkg::AUTO_TEST_CYC_DEF
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic raw_bit,
  input wire logic raw_tgl,
  input wire logic gen_start,
  input wire logic width16,
  input wire logic rd_ack,
  input wire logic selftest_req,
  input wire logic [trng_pkg::ALARM_LINES-1:0] alarm_lines,
  output logic [15:0] rnd_data,
  output logic rnd_valid,
  output logic fail_flag,
  output logic startup_done,
  output logic alarm_inject,
  output logic selftest_busy,
  output logic selftest_done,
  output logic selftest_pass
);
  // pin synchronisers; the source toggles raw_tgl once per new bit
  logic bit_s1_r, bit_s2_r, tgl_s1_r, tgl_s2_r, tgl_s3_r;
  logic [trng_pkg::ALARM_LINES-1:0] al_s1_r, al_s2_r;
  logic stb;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      bit_s1_r <= 1'b0;
      bit_s2_r <= 1'b0;
      tgl_s1_r <= 1'b0;
      tgl_s2_r <= 1'b0;
      tgl_s3_r <= 1'b0;
      al_s1_r <= '0;
      al_s2_r <= '0;
    end else begin
      bit_s1_r <= raw_bit;
      bit_s2_r <= bit_s1_r;
      tgl_s1_r <= raw_tgl;
      tgl_s2_r <= tgl_s1_r;
      tgl_s3_r <= tgl_s2_r;
      al_s1_r <= alarm_lines;
      al_s2_r <= al_s1_r;
    end
  end

  assign stb = tgl_s2_r ^ tgl_s3_r;

  logic tot_fail, onl_fail, onl_pass;

  health_tests u_tests (
    .core_clk(core_clk),
    .rstn(rstn),
    .clr(gen_start),
    .bit_in(bit_s2_r),
    .bit_stb(stb),
    .tot_fail(tot_fail),
    .onl_fail(onl_fail),
    .onl_pass(onl_pass)
  );

  function automatic logic [15:0] mask_word(input logic [15:0] w, input logic wide);
    mask_word = wide ? w : {8'h00, w[7:0]};
  endfunction

  trng_pkg::gen_state_e st_r, st_nxt;
  logic [15:0] shreg_r, shreg_nxt, prev_r, prev_nxt, pend_r, pend_nxt, data_r, data_nxt;
  logic [4:0] bcnt_r, bcnt_nxt;
  logic [5:0] pcnt_r, pcnt_nxt;
  logic have_prev_r, have_prev_nxt, pend_v_r, pend_v_nxt, valid_r, valid_nxt;
  logic fail_r, fail_nxt, sdone_r, sdone_nxt, rep_fail;
  logic [15:0] word_new;
  logic [4:0] blen;

  always_comb begin
    st_nxt = st_r;
    shreg_nxt = shreg_r;
    prev_nxt = prev_r;
    pend_nxt = pend_r;
    data_nxt = data_r;
    bcnt_nxt = bcnt_r;
    pcnt_nxt = pcnt_r;
    have_prev_nxt = have_prev_r;
    pend_v_nxt = pend_v_r;
    valid_nxt = valid_r;
    fail_nxt = fail_r;
    sdone_nxt = sdone_r;
    rep_fail = 1'b0;
    word_new = mask_word({shreg_r[14:0], bit_s2_r}, width16);
    blen = width16 ? trng_pkg::WLEN_16 : trng_pkg::WLEN_8;
    if (rd_ack && valid_r) begin
      valid_nxt = 1'b0;
    end
    unique case (st_r)
      trng_pkg::ST_IDLE, trng_pkg::ST_FAIL: begin
      end
      trng_pkg::ST_START: begin
        // go on from start-up to ST_RUN only on a passing window
        if (onl_pass) begin
          st_nxt = trng_pkg::ST_RUN;
          sdone_nxt = 1'b1;
        end
      end
      trng_pkg::ST_RUN: begin
        if (stb && pend_v_r && pcnt_r != trng_pkg::TF_RUN) begin
          pcnt_nxt = pcnt_r + 6'h01;
        end
        if (stb && !pend_v_r) begin
          shreg_nxt = {shreg_r[14:0], bit_s2_r};
          bcnt_nxt = bcnt_r + 5'h01;
          if (bcnt_r + 5'h01 >= blen) begin
            bcnt_nxt = '0;
            rep_fail = have_prev_r && (word_new == prev_r);
            prev_nxt = word_new;
            have_prev_nxt = 1'b1;
            pend_nxt = word_new;
            pend_v_nxt = 1'b1;
            pcnt_nxt = '0;
          end
        end
        // release only after a stuck run could have shown
        if (pend_v_r && pcnt_r == trng_pkg::TF_RUN && !valid_r) begin
          data_nxt = pend_r;
          valid_nxt = 1'b1;
          pend_v_nxt = 1'b0;
        end
      end
      default: begin
        st_nxt = trng_pkg::ST_FAIL;
      end
    endcase
    if ((tot_fail || onl_fail || rep_fail) && st_r != trng_pkg::ST_IDLE) begin
      st_nxt = trng_pkg::ST_FAIL;
      fail_nxt = 1'b1;
      valid_nxt = 1'b0;
      pend_v_nxt = 1'b0;
      bcnt_nxt = '0;
    end
    // restart clears and begins start-up tests
    if (gen_start) begin
      st_nxt = trng_pkg::ST_START;
      fail_nxt = 1'b0;
      sdone_nxt = 1'b0;
      valid_nxt = 1'b0;
      pend_v_nxt = 1'b0;
      have_prev_nxt = 1'b0;
      bcnt_nxt = '0;
      pcnt_nxt = '0;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      st_r <= trng_pkg::ST_IDLE;
      shreg_r <= 16'h0000;
      prev_r <= 16'h0000;
      pend_r <= 16'h0000;
      data_r <= 16'h0000;
      bcnt_r <= '0;
      pcnt_r <= '0;
      have_prev_r <= 1'b0;
      pend_v_r <= 1'b0;
      valid_r <= 1'b0;
      fail_r <= 1'b0;
      sdone_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      shreg_r <= shreg_nxt;
      prev_r <= prev_nxt;
      pend_r <= pend_nxt;
      data_r <= data_nxt;
      bcnt_r <= bcnt_nxt;
      pcnt_r <= pcnt_nxt;
      have_prev_r <= have_prev_nxt;
      pend_v_r <= pend_v_nxt;
      valid_r <= valid_nxt;
      fail_r <= fail_nxt;
      sdone_r <= sdone_nxt;
    end
  end

  // alarm self-test
  localparam int unsigned AUTO_W_T = trng_pkg::AUTO_W;
  logic [AUTO_W_T-1:0] auto_r, auto_nxt;
  logic [3:0] wcnt_r, wcnt_nxt;
  logic busy_r, busy_nxt, done_r, done_nxt, pass_r, pass_nxt, inj_r, inj_nxt;
  logic al_ok;

  always_comb begin
    // stale levels from a previous test must not count as an answer
    al_ok = &al_s2_r && wcnt_r >= trng_pkg::ALARM_SETTLE;
    auto_nxt = auto_r - AUTO_W_T'(1);
    wcnt_nxt = wcnt_r;
    busy_nxt = busy_r;
    done_nxt = 1'b0;
    pass_nxt = pass_r;
    inj_nxt = inj_r;
    if (auto_r == '0) begin
      auto_nxt = AUTO_W_T'(AUTO_TEST_CYC - 1);
    end
    if (!busy_r && (selftest_req || auto_r == '0)) begin
      busy_nxt = 1'b1;
      inj_nxt = 1'b1;
      wcnt_nxt = '0;
    end else if (busy_r) begin
      // every line must answer the injected alarm
      wcnt_nxt = wcnt_r + 4'h1;
      if (al_ok || wcnt_r == trng_pkg::ALARM_WAIT_CYC) begin
        busy_nxt = 1'b0;
        inj_nxt = 1'b0;
        done_nxt = 1'b1;
        pass_nxt = al_ok;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      auto_r <= AUTO_W_T'(AUTO_TEST_CYC - 1);
      wcnt_r <= '0;
      busy_r <= 1'b0;
      done_r <= 1'b0;
      pass_r <= 1'b0;
      inj_r <= 1'b0;
    end else begin
      auto_r <= auto_nxt;
      wcnt_r <= wcnt_nxt;
      busy_r <= busy_nxt;
      done_r <= done_nxt;
      pass_r <= pass_nxt;
      inj_r <= inj_nxt;
    end
  end

  assign rnd_data = data_r;
  assign rnd_valid = valid_r;
  assign fail_flag = fail_r;
  assign startup_done = sdone_r;
  assign alarm_inject = inj_r;
  assign selftest_busy = busy_r;
  assign selftest_done = done_r;
  assign selftest_pass = pass_r;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);

  property p_start_tests;
    gen_start |=> st_r == trng_pkg::ST_START && !fail_r && !sdone_r;
  endproperty
  a_start_tests: assert property (p_start_tests) else $error("restart did not enter start-up");

  property p_fail_blocks;
    fail_r |-> !valid_r;
  endproperty
  a_fail_blocks: assert property (p_fail_blocks) else $error("word shown while failed");

  property p_tot_drop;
    tot_fail && !gen_start && st_r != trng_pkg::ST_IDLE |=> !valid_r && !pend_v_r && fail_r;
  endproperty
  a_tot_drop: assert property (p_tot_drop) else $error("pending word kept after failure");

  property p_onl_fail;
    onl_fail && !gen_start && st_r != trng_pkg::ST_IDLE |=> fail_r;
  endproperty
  a_onl_fail: assert property (p_onl_fail) else $error("online defect not flagged");

  property p_no_out_before_pass;
    !sdone_r |-> !valid_r;
  endproperty
  a_no_out_before_pass: assert property (p_no_out_before_pass) else $error("output before start-up");

  property p_width8;
    $rose(pend_v_r) && !$past(width16) |-> pend_r[15:8] == 8'h00;
  endproperty
  a_width8: assert property (p_width8) else $error("8-bit word has high bits");

  property p_repeat;
    rep_fail && !gen_start |=> fail_r && st_r == trng_pkg::ST_FAIL;
  endproperty
  a_repeat: assert property (p_repeat) else $error("repeated word not a failure");

  sequence s_test_begin;
    !busy_r && selftest_req;
  endsequence
  sequence s_test_end;
    ##[1:16] done_r;
  endsequence
  property p_selftest;
    s_test_begin |=> busy_r && inj_r ##0 s_test_end;
  endproperty
  a_selftest: assert property (p_selftest) else $error("self-test did not run");

  property p_auto_test;
    !busy_r && auto_r == '0 |=> busy_r;
  endproperty
  a_auto_test: assert property (p_auto_test) else $error("timer did not start self-test");

  property p_sticky;
    fail_r && !gen_start |=> fail_r;
  endproperty
  a_sticky: assert property (p_sticky) else $error("failure flag dropped");
endmodule

/* sim/cpu_reader.sv */
`timescale 1ns/1ns
module cpu_reader (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic rnd_valid,
  input wire logic fail_flag,
  input wire logic [15:0] rnd_data,
  output logic rd_ack,
  output logic got_word,
  output logic [15:0] got_data
);
  int wait_r;
  // valid checked first, words under failure dropped
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rd_ack <= 1'b0;
      got_word <= 1'b0;
      got_data <= 16'h0000;
      wait_r <= 0;
    end else begin
      got_word <= 1'b0;
      if (rd_ack) begin
        rd_ack <= 1'b0;
        if (rnd_valid === 1'b1 && fail_flag === 1'b0) begin
          got_word <= 1'b1;
          got_data <= rnd_data;
        end
      end else if (rnd_valid === 1'b1 && fail_flag === 1'b0) begin
        // random latency so both prompt and slow reads occur
        if (wait_r == 0) begin
          rd_ack <= 1'b1;
          wait_r <= $urandom_range(3, 0);
        end else begin
          wait_r <= wait_r - 1;
        end
      end
    end
  end
endmodule

/* sim/tb_trng_health_gate.sv */
`timescale 1ns/1ns
module tb_trng_health_gate;
  logic core_clk, rstn, raw_bit, raw_tgl, gen_start, width16, rd_ack, selftest_req;
  logic [trng_pkg::ALARM_LINES-1:0] alarm_lines;
  logic [15:0] rnd_data, got_data, prev_w;
  logic rnd_valid, fail_flag, startup_done, alarm_inject, selftest_busy, selftest_done;
  logic selftest_pass, got_word, sensor_ok;
  int fail_count, tests_run, pos, lim, n8, n16, ones, n_done;
  bit hist[$];

  trng_health_gate #(.AUTO_TEST_CYC(64)) dut (.core_clk(core_clk), .rstn(rstn),
    .raw_bit(raw_bit), .raw_tgl(raw_tgl), .gen_start(gen_start), .width16(width16),
    .rd_ack(rd_ack), .selftest_req(selftest_req), .alarm_lines(alarm_lines),
    .rnd_data(rnd_data), .rnd_valid(rnd_valid), .fail_flag(fail_flag),
    .startup_done(startup_done), .alarm_inject(alarm_inject),
    .selftest_busy(selftest_busy), .selftest_done(selftest_done),
    .selftest_pass(selftest_pass));
  cpu_reader host (.core_clk(core_clk), .rstn(rstn), .rnd_valid(rnd_valid),
    .fail_flag(fail_flag), .rnd_data(rnd_data), .rd_ack(rd_ack), .got_word(got_word),
    .got_data(got_data));

  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  task automatic chk1(string nm, logic e, logic g);
    tests_run++;
    if (g !== e) begin
      fail_count++;
      $display("Error %s expected %b seen %b", nm, e, g);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  function automatic int find(logic [15:0] w, int len);
    for (int p = pos; p + len <= lim && p + len <= hist.size(); p++) begin
      logic [15:0] v;
      v = 16'h0000;
      for (int k = 0; k < len; k++) v = {v[14:0], 1'(hist[p + k])};
      if (v === w) return p;
    end
    return -1;
  endfunction

  // words are msb-first slices of the raw stream, never from bits after a stuck start
  task automatic check_word(logic [15:0] w);
    int p, len;
    len = 8;
    p = (w[15:8] === 8'h00) ? find(w, 8) : -1;
    if (p < 0) begin
      len = 16;
      p = find(w, 16);
    end
    chk1("word_in_stream", 1'b1, p >= 0);
    chk1("word_repeat", 1'b1, w !== prev_w);
    if (p >= 0) pos = p + len;
    if (len == 8) n8++;
    else n16++;
    prev_w = w;
  endtask

  task automatic send_bit(bit b);
    @(posedge core_clk) raw_bit <= b;
    @(posedge core_clk) raw_tgl <= ~raw_tgl;
    hist.push_back(b);
    ones += b;
    repeat (3) @(posedge core_clk);
  endtask

  task automatic run_bits(int n, int mode);
    for (int i = 0; i < n; i++) begin
      // hold the stream while a word waits, so the skipped span stays even
      if (mode == 1) begin
        repeat (3) @(posedge core_clk);
        while (rnd_valid === 1'b1) @(posedge core_clk);
      end
      send_bit(mode == 0 ? 1'($urandom) : mode == 1 ? 1'(i % 2) : 1'b0);
    end
  endtask

  task automatic startup(int mode);
    logic ok;
    @(posedge core_clk) gen_start <= 1'b1;
    @(posedge core_clk) gen_start <= 1'b0;
    hist.delete();
    pos = 0;
    lim = 1 << 30;
    ones = 0;
    prev_w = 16'hxxxx;
    @(posedge core_clk);
    chk1("fail_after_restart", 1'b0, fail_flag);
    for (int i = 0; i < 256; i++)
      send_bit(mode == 0 ? 1'($urandom) : 1'(i % 4 == 0) ^ 1'(mode == 2));
    ok = (ones >= 96 && ones <= 160);
    repeat (4) @(posedge core_clk);
    chk1("startup_done", ok, startup_done);
    chk1("fail_window", !ok, fail_flag);
  endtask

  task automatic selftest_cycle(logic ok);
    int n;
    while (selftest_busy !== 1'b0) @(posedge core_clk);
    sensor_ok <= ok;
    selftest_req <= 1'b1;
    @(posedge core_clk) selftest_req <= 1'b0;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (selftest_done !== 1'b1 && n < 20);
    chk1("selftest_done", 1'b1, selftest_done);
    chk1("selftest_pass", ok, selftest_pass);
  endtask

  // sensor answers the injected alarm only when healthy
  always @(posedge core_clk) alarm_lines <= (alarm_inject === 1'b1 && sensor_ok) ? '1 : '0;

  always @(posedge core_clk) begin
    if (got_word === 1'b1) check_word(got_data);
    if (selftest_done === 1'b1) begin
      n_done++;
      chk1("auto_pass", sensor_ok, selftest_pass);
    end
    if (fail_flag === 1'b1) chk1("valid_while_fail", 1'b0, rnd_valid);
    if (rnd_valid === 1'b1) chk1("valid_before_start", 1'b1, startup_done);
  end

  initial begin
    #400000;
    fail_count++;
    $display("Error watchdog expected finish seen timeout");
    tally_and_finish();
  end

  initial begin
    rstn = 1'b0;
    raw_bit = 1'b0;
    raw_tgl = 1'b0;
    gen_start = 1'b0;
    width16 = 1'b0;
    selftest_req = 1'b0;
    sensor_ok = 1'b1;
    alarm_lines = '0;
    {fail_count, tests_run, pos, n8, n16, ones, n_done} = '0;
    lim = 1 << 30;
    prev_w = 16'hxxxx;
    void'($urandom(52));
    repeat (4) @(posedge core_clk);
    chk1("valid_in_reset", 1'b0, rnd_valid);
    chk1("busy_in_reset", 1'b0, selftest_busy);
    rstn <= 1'b1;
    run_bits(20, 0);
    chk1("idle_startup", 1'b0, startup_done);
    startup(0);
    run_bits(150, 0);
    width16 <= 1'b1;
    run_bits(250, 0);
    chk1("words8_seen", 1'b1, n8 > 0);
    chk1("words16_seen", 1'b1, n16 > 0);
    lim = hist.size();
    run_bits(40, 2);
    chk1("fail_stuck", 1'b1, fail_flag);
    run_bits(40, 0);
    chk1("fail_sticky", 1'b1, fail_flag);
    startup(1);
    startup(2);
    startup(0);
    width16 <= 1'b0;
    run_bits(120, 1);
    chk1("fail_repeat", 1'b1, fail_flag);
    selftest_cycle(1'b1);
    selftest_cycle(1'b0);
    chk1("auto_selftest", 1'b1, n_done > 2);
    tally_and_finish();
  end
endmodule
